// [hdl/sac_adc_ctrl.sv]
// What this block does
// RQ1 - with converter on, convert the selected channel over and over
// RQ2 - clearing on stops any conversion; setting it starts converting
// RQ3 - each completion loads both result registers and sets the done flag
// RQ4 - result_high read or any status write clears done; result_low read does not
// RQ5 - done flag is read-only; all other status bits read and write
// RQ6 - results overwritten at each completion, no latched copy kept
// RQ7 - software polls done, reads low, then high for ten bits
// RQ8 - software polls done, reads only high for eight bits
// RQ9 - channel change mid-conversion aborts, clears done, restarts new channel
// RQ10 - four channel bits pick input zero to fifteen in binary
// RQ11 - rate bit set gives clock divided by two, clear by four
// RQ12 - software always writes zero to status bit four
// RQ13 - input above high reference gives high FF, low 03, no overflow
// RQ14 - input below low reference gives all-zero result
// RQ15 - result_high shows result bits nine down to two, read-only
// RQ16 - result_low shows bits one and zero, upper six read zero
// RQ17 - wait mode leaves conversion untouched
// RQ18 - halt disables converter; software waits after wakeup
// RQ19 - all three registers reset to zero
// RQ20 - status at 0070h, result_high at 0071h, result_low at 0072h
// RQ21 - fixed-length conversion: sampling then ten msb-first bit trials
// RQ22 - no interrupt; completion seen only by polling done
//
// Purpose: register file and run control of a 10-bit approximation converter
// Assumes: comparator output comp_i high when input is at or above dac code
// Notes: there is no wait input; wait mode simply does not reach this block
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_adc_ctrl #(
  parameter int SAMPLE_TICKS = `SAC_SAMPLE_TICKS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire sac_pkg::sac_addr_type addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic halt_i,
  input wire logic comp_i,
  output logic [3:0] channel_o,
  output logic sample_o,
  output sac_pkg::sac_result_type dac_code_o
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic done_flag;
    logic rate_fast;
    logic converter_on;
    logic rsvd;
    logic [3:0] chan;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [7:0] rdata;
    logic start;
    logic abort;
  } sac_ctl_type;

  sac_ctl_type s_q;
  sac_ctl_type s_d;

  sac_conv_if cv ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input sac_addr_type a,
                               input sac_addr_type off);
    hit = (a == off);
  endfunction : hit

  logic wr_csr;
  logic rd_csr;
  logic rd_high;
  logic rd_low;
  logic chan_change;
  logic run_next;
  logic [7:0] csr_view;

  // RQ20 fixed offsets
  assign wr_csr = wr_i && hit(addr_i, `SAC_OFF_CSR);
  assign rd_csr = rd_i && hit(addr_i, `SAC_OFF_CSR);
  assign rd_high = rd_i && hit(addr_i, `SAC_OFF_RES_HIGH);
  assign rd_low = rd_i && hit(addr_i, `SAC_OFF_RES_LOW);

  assign csr_view = {s_q.done_flag, s_q.rate_fast, s_q.converter_on,
                     s_q.rsvd, s_q.chan};

  // RQ9 channel written to a different value while running
  assign chan_change = wr_csr && s_q.converter_on && cv.busy &&
    (wdata_i[`SAC_CSR_CHAN_HI:`SAC_CSR_CHAN_LO] != s_q.chan);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.start = 1'b0;

    // RQ5 writable fields; done kept out
    if (wr_csr) begin
      s_d.rate_fast = wdata_i[`SAC_CSR_RATE];
      s_d.converter_on = wdata_i[`SAC_CSR_ON];
      // RQ12 bit four stored as written
      s_d.rsvd = wdata_i[`SAC_CSR_RSVD];
      s_d.chan = wdata_i[`SAC_CSR_CHAN_HI:`SAC_CSR_CHAN_LO];
    end

    // RQ4 clear on high read or status write
    if (wr_csr || rd_high) begin
      s_d.done_flag = 1'b0;
    end

    // RQ3 completion loads results and sets done
    // RQ6 plain overwrite, no shadow copy
    if (cv.done) begin
      // RQ15 high byte carries bits nine to two
      s_d.res_high = cv.result[`SAC_RES_BITS-1:2];
      // RQ16 low byte carries bits one and zero
      s_d.res_low = {6'h00, cv.result[1:0]};
      // set beats a clear landing in the same cycle
      s_d.done_flag = 1'b1;
    end

    // reads answer one cycle later; unmapped reads give zero
    if (rd_csr) begin
      s_d.rdata = csr_view;
    end else if (rd_high) begin
      s_d.rdata = s_q.res_high;
    end else if (rd_low) begin
      s_d.rdata = s_q.res_low;
    end

    // RQ17 no wait input, so wait mode never stops a conversion
    // RQ18 halt disables the converter
    run_next = s_d.converter_on && !halt_i;

    // RQ2 off or halted stops the engine
    // RQ9 channel change aborts current conversion
    s_d.abort = !run_next || chan_change;

    // RQ1 restart as soon as the engine falls idle
    s_d.start = run_next && !chan_change && !cv.busy && !s_q.start &&
                !s_q.abort;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    // RQ19 all registers clear on reset except abort, which is set
    if (!rstn_i) begin
      s_q <= '{abort: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  assign cv.start = s_q.start;
  assign cv.abort = s_q.abort;
  // RQ11 rate bit drives the divider
  assign cv.fast = s_q.rate_fast;
  assign cv.comp = comp_i;

  sac_sar_engine #(
    .SAMPLE_TICKS(SAMPLE_TICKS)
  ) u_engine (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .cv(cv)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // RQ22 no interrupt output; done is polled
  assign rdata_o = s_q.rdata;
  // RQ10 channel code passed straight to the input mux
  assign channel_o = s_q.chan;
  assign sample_o = cv.sample;
  assign dac_code_o = cv.code;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_done_sets_flag: assert property ( // RQ3
    cv.done |=> s_q.done_flag)
    else $error("done flag not set at completion");

  a_result_loaded: assert property ( // RQ15
    cv.done |=> s_q.res_high == $past(cv.result[9:2]) &&
                s_q.res_low[1:0] == $past(cv.result[1:0]))
    else $error("result registers not loaded");

  a_low_upper_zero: assert property ( // RQ16
    s_q.res_low[7:2] == 6'h00)
    else $error("result_low upper bits not zero");

  a_high_read_clears: assert property ( // RQ4
    rd_high && !cv.done |=> !s_q.done_flag)
    else $error("high read did not clear done");

  a_low_read_keeps: assert property ( // RQ4
    rd_low && s_q.done_flag |=> s_q.done_flag)
    else $error("low read disturbed done");

  a_flag_readonly: assert property ( // RQ5
    wr_csr && wdata_i[7] && !cv.done |=> !s_q.done_flag)
    else $error("done flag took written value");

  a_csr_readback: assert property ( // RQ5
    wr_csr ##1 rd_csr |=> rdata_o[6:0] == $past(wdata_i[6:0], 2))
    else $error("status bits not read back");

  a_chan_binary: assert property ( // RQ10
    wr_csr |=> channel_o == $past(wdata_i[3:0]))
    else $error("channel select not applied");

  a_off_stops: assert property ( // RQ2
    wr_csr && !wdata_i[5] |=> ##1 !cv.busy)
    else $error("conversion continued after off");

  a_halt_stops: assert property ( // RQ18
    halt_i |=> ##1 !cv.busy)
    else $error("conversion continued in halt");

  a_chan_abort: assert property ( // RQ9
    chan_change |=> s_q.abort ##1 !cv.busy)
    else $error("channel change did not abort");

  a_back_to_back: assert property ( // RQ1
    cv.done && s_q.converter_on && !halt_i && !wr_csr |-> ##2 cv.busy)
    else $error("conversion not restarted");

  a_sat_high: assert property ( // RQ13
    cv.done && cv.result == 10'h3ff |=> s_q.res_high == 8'hff &&
                                        s_q.res_low == 8'h03)
    else $error("saturated result misplaced");

  a_zero_result: assert property ( // RQ14
    cv.done && cv.result == 10'h000 |=> s_q.res_high == 8'h00 &&
                                        s_q.res_low == 8'h00)
    else $error("zero result not zero");

  a_read_one_cycle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");

  a_rate_applied: assert property ( // RQ11
    wr_csr |=> cv.fast == $past(wdata_i[6]))
    else $error("rate bit not applied");

  a_on_applied: assert property ( // RQ2
    wr_csr |=> s_q.converter_on == $past(wdata_i[5]))
    else $error("on bit not applied");

  a_rsvd_stored: assert property ( // RQ5
    wr_csr |=> s_q.rsvd == $past(wdata_i[4]))
    else $error("bit four not stored");

  a_no_load_idle: assert property ( // RQ6
    !cv.done |=> $stable(s_q.res_high) && $stable(s_q.res_low))
    else $error("result changed without completion");

  a_flag_needs_done: assert property ( // RQ3
    !s_q.done_flag && !cv.done |=> !s_q.done_flag)
    else $error("done flag set without completion");

  a_write_clears: assert property ( // RQ4
    wr_csr && !cv.done |=> !s_q.done_flag)
    else $error("status write did not clear done");

  a_high_read_data: assert property ( // RQ15
    rd_high |=> rdata_o == $past(s_q.res_high))
    else $error("result_high read data wrong");

  a_low_read_data: assert property ( // RQ16
    rd_low |=> rdata_o == $past(s_q.res_low))
    else $error("result_low read data wrong");

  a_csr_read_data: assert property ( // RQ5
    rd_csr |=> rdata_o == $past(csr_view))
    else $error("status read data wrong");

  a_unmapped_zero: assert property ( // RQ20
    rd_i && !rd_csr && !rd_high && !rd_low |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  a_write_no_data: assert property ( // RQ5
    wr_i |=> rdata_o == 8'h00)
    else $error("read data after a write");

  a_abort_idles: assert property ( // RQ2
    s_q.abort |=> !cv.busy)
    else $error("engine busy after abort");

  a_no_sample_idle: assert property ( // RQ21
    !cv.busy |-> !cv.sample)
    else $error("sampling while idle");

  a_fresh_code: assert property ( // RQ21
    $rose(cv.sample) |-> cv.code == 10'h000)
    else $error("trial code not cleared at sample");

  a_start_needs_run: assert property ( // RQ1
    s_q.start |-> s_q.converter_on && !s_q.abort)
    else $error("start while off or aborting");

  a_start_busy: assert property ( // RQ1
    s_q.start |=> cv.busy)
    else $error("start did not begin conversion");

  a_chan_stable: assert property ( // RQ10
    !wr_csr |=> $stable(channel_o))
    else $error("channel changed without write");

  a_done_pulse: assert property ( // RQ3
    cv.done |=> !cv.done)
    else $error("completion longer than one cycle");

  a_halt_no_start: assert property ( // RQ18
    halt_i |=> !s_q.start)
    else $error("start issued in halt");

  c_conversion_done: cover property (cv.done);
  c_chan_switch: cover property (chan_change);
  c_ten_bit_read: cover property (
    s_q.done_flag && rd_low ##1 rd_high);
  c_fast_conversion: cover property (s_q.rate_fast && cv.done);
  c_halt_entry: cover property (halt_i && cv.busy);

endmodule : sac_adc_ctrl

`default_nettype wire

// [hdl/sac_conv_if.sv]
// Purpose: link between register/control logic and the approximation engine
// Assumes: single clock domain
// Notes: comp carries the analog comparator level into the engine
`timescale 1ns/1ns
`default_nettype none

interface sac_conv_if;
  import sac_pkg::*;
  logic start;
  logic abort;
  logic fast;
  logic comp;
  logic busy;
  logic done;
  logic sample;
  sac_result_type result;
  sac_result_type code;

  modport ctl (
    output start, abort, fast, comp,
    input busy, done, sample, result, code
  );
  modport eng (
    input start, abort, fast, comp,
    output busy, done, sample, result, code
  );
endinterface : sac_conv_if

`default_nettype wire

// [hdl/sac_defines.svh]
// Purpose: constants for the converter control block
// Assumes: byte-wide registers on a plain strobe port
// Notes: every offset, field position, reset value and count lives here
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SAC_ADDR_W 16
`define SAC_OFF_CSR 16'h0070
`define SAC_OFF_RES_HIGH 16'h0071
`define SAC_OFF_RES_LOW 16'h0072

// ----------------------------------------------------------------
// control/status fields
// ----------------------------------------------------------------
`define SAC_CSR_DONE 7
`define SAC_CSR_RATE 6
`define SAC_CSR_ON 5
`define SAC_CSR_RSVD 4
`define SAC_CSR_CHAN_HI 3
`define SAC_CSR_CHAN_LO 0
`define SAC_RESET_VAL 8'h00

// ----------------------------------------------------------------
// conversion timing, in system clocks and converter clocks
// ----------------------------------------------------------------
`define SAC_RES_BITS 10
`define SAC_DIV_FAST 2
`define SAC_DIV_SLOW 4
`define SAC_SAMPLE_TICKS 2

`endif

// [hdl/sac_pkg.sv]
// Purpose: shared types of the converter control block
// Assumes: constants come from sac_defines.svh
// Notes: types only
`include "sac_defines.svh"

package sac_pkg;

  typedef logic [`SAC_ADDR_W-1:0] sac_addr_type;
  typedef logic [`SAC_RES_BITS-1:0] sac_result_type;

  // engine phases, one-hot
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_TRIAL = 3'b100
  } sac_phase_type;

endpackage : sac_pkg

// [hdl/sac_sar_engine.sv]
// Purpose: converter clock divider and successive approximation sequence
// Assumes: comparator settles within one converter clock of a code change
// Notes: abort beats start; result and done come from flops
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_sar_engine #(
  parameter int SAMPLE_TICKS = `SAC_SAMPLE_TICKS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  sac_conv_if.eng cv
);
  import sac_pkg::*;

  typedef struct packed {
    sac_phase_type phase;
    logic [1:0] div;
    logic [3:0] cnt;
    sac_result_type code;
    sac_result_type result;
    logic done;
    logic sample;
  } sac_eng_type;

  sac_eng_type s_q;
  sac_eng_type s_d;
  logic tick;

  assign tick = (s_q.div == 2'd0);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // RQ11 rate divider
    if (tick) begin
      s_d.div = cv.fast ? 2'(`SAC_DIV_FAST - 1) : 2'(`SAC_DIV_SLOW - 1);
    end else begin
      s_d.div = s_q.div - 2'd1;
    end
    // RQ21 sample then msb-first trials
    unique case (s_q.phase)
      SAC_IDLE: begin
        if (cv.start) begin
          s_d.phase = SAC_SAMPLE;
          s_d.cnt = 4'(SAMPLE_TICKS - 1);
          s_d.sample = 1'b1;
          s_d.code = '0;
        end
      end
      SAC_SAMPLE: begin
        if (tick) begin
          if (s_q.cnt == 4'd0) begin
            s_d.phase = SAC_TRIAL;
            s_d.sample = 1'b0;
            s_d.cnt = 4'(`SAC_RES_BITS - 1);
            s_d.code[`SAC_RES_BITS-1] = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - 4'd1;
          end
        end
      end
      SAC_TRIAL: begin
        // RQ13 RQ14 comparator level alone decides every bit
        if (tick) begin
          s_d.code[s_q.cnt] = cv.comp;
          if (s_q.cnt == 4'd0) begin
            s_d.phase = SAC_IDLE;
            s_d.done = 1'b1;
            s_d.result = s_d.code;
          end else begin
            s_d.code[s_q.cnt - 4'd1] = 1'b1;
            s_d.cnt = s_q.cnt - 4'd1;
          end
        end
      end
      default: begin
        s_d.phase = SAC_IDLE;
      end
    endcase
    // RQ2 stop at once
    if (cv.abort) begin
      s_d.phase = SAC_IDLE;
      s_d.sample = 1'b0;
      s_d.done = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_q <= '{phase: SAC_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cv.busy = (s_q.phase != SAC_IDLE);
  assign cv.done = s_q.done;
  assign cv.sample = s_q.sample;
  assign cv.result = s_q.result;
  assign cv.code = s_q.code;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fast_divide: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RQ11
    tick && cv.fast |=> !tick ##1 tick)
    else $error("fast divider not by two");
  a_slow_divide: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RQ11
    tick && !cv.fast |=> !tick [*3] ##1 tick)
    else $error("slow divider not by four");

endmodule : sac_sar_engine

`default_nettype wire

// [tb/sac_analog_model.sv]
// Purpose: analog inputs, sample/hold and comparator beside the control
// Assumes: levels are set by the bench per channel, in dac code units
// Notes: levels above 3ff or below zero model inputs past the references
`timescale 1ns/1ns
`default_nettype none

module sac_analog_model (
  input wire logic clk_sys_i,
  input wire logic [3:0] channel_i,
  input wire logic sample_i,
  input wire sac_pkg::sac_result_type dac_code_i,
  output logic comp_o
);
  import sac_pkg::*;
  logic signed [11:0] level [16];
  logic signed [11:0] held;
  initial begin
    held = 12'sh000;
    foreach (level[i]) level[i] = 12'sh000;
  end
  always @(posedge clk_sys_i) begin
    if (sample_i) begin
      held <= level[channel_i];
    end
  end
  // comparator against trial code
  // held value only changes while sampling, as a real hold capacitor
  assign comp_o = held >= $signed({2'b00, dac_code_i});
endmodule : sac_analog_model

`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: plain strobe register port, one 20 MHz clock
// Notes: poll-based; conversion times are compared, not matched exactly
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module testbench;
  import sac_pkg::*;
  localparam int LIMIT = 60000;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  sac_addr_type addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic halt_i = 1'b0;
  wire logic comp_w;
  logic [7:0] rdata_o;
  logic [3:0] channel_o;
  logic sample_o;
  sac_result_type dac_code_o;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int t_slow;
  int t_fast;
  logic [7:0] rv;

  always #25 clk_sys_i = ~clk_sys_i;

  sac_adc_ctrl #(.SAMPLE_TICKS(2)) dut_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .halt_i(halt_i), .comp_i(comp_w), .channel_o(channel_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o)
  );
  sac_analog_model am_u (
    .clk_sys_i(clk_sys_i), .channel_i(channel_o), .sample_i(sample_o),
    .dac_code_i(dac_code_o), .comp_o(comp_w)
  );

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input sac_addr_type a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task rd(input sac_addr_type a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task wait_done(output int took);
    int t0;
    t0 = cycles;
    rv = 8'h00;
    while (rv[7] !== 1'b1 && cycles - t0 < 400) rd(`SAC_OFF_CSR, rv);
    took = cycles - t0;
    chk({7'h00, rv[7]}, 8'h01);
  endtask : wait_done

  // off, then clear a done left over, so no stale result is taken
  task start(input logic [7:0] ctl);
    wr(`SAC_OFF_CSR, 8'h00);
    rd(`SAC_OFF_RES_HIGH, rv);
    wr(`SAC_OFF_CSR, ctl);
  endtask : start

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h00);
    rd(`SAC_OFF_RES_HIGH, rv);
    chk(rv, 8'h00);
    rd(`SAC_OFF_RES_LOW, rv);
    chk(rv, 8'h00);
    rd(16'h0073, rv);
    chk(rv, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_access;
    // every status write keeps bit four zero
    wr(`SAC_OFF_CSR, 8'h4f);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h4f);
    wr(`SAC_OFF_CSR, 8'h80);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h00);
    wr(`SAC_OFF_RES_HIGH, 8'h55);
    rd(`SAC_OFF_RES_HIGH, rv);
    chk(rv, 8'h00);
    wr(`SAC_OFF_RES_LOW, 8'hff);
    rd(`SAC_OFF_RES_LOW, rv);
    chk(rv, 8'h00);
    $display("test access done");
  endtask : t_access

  task t_read10;
    int n;
    am_u.level[3] = 12'sh2a5;
    am_u.level[9] = 12'sh155;
    start(8'h23);
    wait_done(t_slow);
    chk({4'h0, channel_o}, 8'h03);
    rd(`SAC_OFF_RES_LOW, rv);
    chk(rv, 8'h01);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'ha3);
    rd(`SAC_OFF_RES_HIGH, rv);
    chk(rv, 8'ha9);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h23);
    wait_done(n);
    wr(`SAC_OFF_CSR, 8'h23);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h23);
    $display("test read10 done");
  endtask : t_read10

  task t_levels;
    logic signed [11:0] lv [3];
    logic [7:0] hi [3];
    logic [7:0] lo [3];
    lv = '{12'sh7ff, 12'shf00, 12'sh155};
    hi = '{8'hff, 8'h00, 8'h55};
    lo = '{8'h03, 8'h00, 8'h01};
    for (int i = 0; i < 3; i++) begin
      am_u.level[0] = lv[i];
      start(8'h60);
      wait_done(t_fast);
      rd(`SAC_OFF_RES_HIGH, rv);
      chk(rv, hi[i]);
      rd(`SAC_OFF_RES_LOW, rv);
      chk(rv, lo[i]);
    end
    chk({7'h00, t_slow > t_fast + 16}, 8'h01);
    chk({7'h00, t_slow >= 48}, 8'h01);
    $display("test levels done");
  endtask : t_levels

  task t_chan;
    int n;
    start(8'h23);
    wait_done(n);
    repeat (10) @(posedge clk_sys_i);
    wr(`SAC_OFF_CSR, 8'h29);
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h29);
    chk({4'h0, channel_o}, 8'h09);
    wait_done(n);
    rd(`SAC_OFF_RES_HIGH, rv);
    chk(rv, 8'h55);
    $display("test channel done");
  endtask : t_chan

  task t_stop(input logic use_halt);
    int n;
    start(8'h23);
    repeat (10) @(posedge clk_sys_i);
    if (use_halt) halt_i <= 1'b1;
    else wr(`SAC_OFF_CSR, 8'h03);
    rd(`SAC_OFF_RES_HIGH, rv);
    n = 0;
    repeat (200) begin
      @(posedge clk_sys_i);
      if (sample_o !== 1'b0) n++;
    end
    chk(n[7:0], 8'h00);
    rd(`SAC_OFF_CSR, rv);
    chk({7'h00, rv[7]}, 8'h00);
    if (use_halt) halt_i <= 1'b0;
    else wr(`SAC_OFF_CSR, 8'h23);
    wait_done(n);
    $display("test stop done");
  endtask : t_stop

  task t_rerun;
    start(8'h6f);
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(`SAC_OFF_CSR, rv);
    chk(rv, 8'h00);
    chk({3'h0, sample_o, channel_o}, 8'h00);
    $display("test rerun done");
  endtask : t_rerun

  // ----------------------------------------------------------------
  // verdict and run control
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      report_and_stop;
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset;
    t_access;
    t_read10;
    t_levels;
    t_chan;
    t_stop(1'b0);
    t_stop(1'b1);
    t_rerun;
    report_and_stop;
  end
endmodule : testbench

`default_nettype wire
